// ---- logic/usbh_regs.svh ----
// Function
// R01: command/data select high marks a command byte; low marks a data byte.
// R02: parallel access counts only with chip select low; strobes are active low.
// R03: bytes travel over an eight-bit tri-state data bus.
// R04: after reset, pending requests pull the interrupt output low.
// R05: strap pin sampled during reset: low parallel, high serial.
// R06: after reset the strap pin becomes serial transmit data output.
// R07: in serial mode the host sends on the receive input, idling high.
// R08: in host mode, connection indicator is low while a device is attached.
// R09: device is in reset while the external reset input is high.
// R10: during any reset, drive an active-high and an active-low reset output.
// R11: separate 64-byte buffers for host endpoint input and output.
// R12: talks to full-speed and low-speed peripherals.
// R13: performs control, bulk and interrupt transfers.
// R14: detects attach and detach alone and reports each to the processor.
// R15: host and peripheral operation switch at run time.
// R16: serial mode starts at 9600 bit/s until a divider command changes it.
// R17: operation status is 51h on success and 5fh on failure.
// R18: status-read returns pending interrupt status and drops the request.
// R19: data bus driven only while chip select and read strobe are low.
// R20: interrupt output stays high in reset until an event is pending.
`ifndef USBH_REGS_SVH
`define USBH_REGS_SVH

`define UH_CLK_HZ 10000000
`define UH_BAUD_DEF 9600
`define UH_DIV_DEF 16'((`UH_CLK_HZ) / (`UH_BAUD_DEF))
`define UH_BUF_BYTES 7'h40

`define UH_CMD_GET_VER 8'h01
`define UH_CMD_SET_BAUD 8'h02
`define UH_CMD_CHECK 8'h06
`define UH_CMD_SET_MODE 8'h15
`define UH_CMD_TEST_CONN 8'h16
`define UH_CMD_GET_STATUS 8'h22
`define UH_CMD_RD_DATA 8'h28
`define UH_CMD_WR_DATA 8'h2b
`define UH_CMD_ISSUE 8'h4e

`define UH_RET_SUCCESS 8'h51
`define UH_RET_ABORT 8'h5f
`define UH_MODE_HOST 8'h06

`define UH_INT_XFER_OK 8'h14
`define UH_INT_CONNECT 8'h15
`define UH_INT_DISCONNECT 8'h16
`define UH_INT_XFER_ERR 8'h17

`define UH_VER_FLAG 8'h80
`define UH_ISSUE_TYPE_LSB 4

`endif

// ---- logic/usbh_pkg.sv ----
package usbh_pkg;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cmd_data_select;
        logic [7:0] data;
    } usbh_pins_t;

    typedef enum logic [1:0] {
        USBH_XFER_CONTROL,
        USBH_XFER_BULK,
        USBH_XFER_INTERRUPT,
        USBH_XFER_RSVD
    } usbh_xfer_type_t;

    typedef struct packed {
        logic valid;
        usbh_xfer_type_t ttype;
        logic [3:0] ep;
        logic low_speed;
        logic [6:0] len;
    } usbh_xfer_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } usbh_byte_t;

    typedef enum {
        USBH_ST_IDLE,
        USBH_ST_ARG,
        USBH_ST_WDATA,
        USBH_ST_RESP,
        USBH_ST_RDLEN,
        USBH_ST_RDATA
    } usbh_state_t;

endpackage : usbh_pkg

// ---- logic/usbh_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module usbh_fifo #(
    parameter int W = 8,
    parameter int D = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign o_ready = (cnt_reg != CW'(D));
    assign o_valid = (cnt_reg != '0);
    assign o_data = mem_reg[rptr_reg];

    always_comb begin
        push = i_valid && o_ready;
        pop = o_valid && i_ready;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        cnt_next = cnt_reg;
        if (push) begin
            wptr_next = (wptr_reg == AW'(D - 1)) ? '0 : AW'(wptr_reg + 1'b1);
        end
        if (pop) begin
            rptr_next = (rptr_reg == AW'(D - 1)) ? '0 : AW'(rptr_reg + 1'b1);
        end
        if (push && !pop) begin
            cnt_next = CW'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = CW'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage holds no reset: its contents are only read while counted valid
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wptr_reg] <= i_data;
        end
    end
endmodule : usbh_fifo
`default_nettype wire

// ---- logic/usbh_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usbh_regs.svh"
module usbh_port #(
    parameter logic [7:0] VERSION = 8'h01 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ext_reset_in,
    input wire usbh_pkg::usbh_pins_t i_pins,
    output logic [7:0] o_host_data_bus,
    output logic o_host_data_bus_oe,
    output logic o_int_n,
    input wire logic i_txd,
    output logic o_txd,
    output logic o_txd_oe,
    input wire logic i_rxd,
    output logic o_rst,
    output logic o_rst_n,
    output logic o_link_connected_n,
    output logic o_host_mode,
    input wire logic i_dev_attached,
    input wire logic i_low_speed,
    output usbh_pkg::usbh_xfer_t o_xfer,
    input wire logic i_xfer_done,
    input wire logic i_xfer_ok,
    input wire usbh_pkg::usbh_byte_t i_usb_in,
    output logic o_usb_in_ready,
    input wire logic [5:0] i_out_idx,
    output logic [7:0] o_out_data
);
    import usbh_pkg::*;

    // pin synchronisers, reset to the idle levels: pulled-up pins high, external reset low
    usbh_pins_t pin_s1_reg, pin_s2_reg, pin_prev_reg;
    logic ext_s1_reg, ext_s2_reg, strap_s1_reg, strap_s2_reg, rx_s1_reg, rx_s2_reg;
    logic core_rst, serial_reg, serial_next, armed_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            serial_reg <= 1'b1;
            armed_reg <= 1'b0;
        end else begin
            pin_s1_reg <= i_pins;
            pin_s2_reg <= pin_s1_reg;
            ext_s1_reg <= i_ext_reset_in;
            ext_s2_reg <= ext_s1_reg;
            rx_s1_reg <= i_rxd;
            rx_s2_reg <= rx_s1_reg;
            serial_reg <= serial_next;
            armed_reg <= !ext_s2_reg;
        end
    end

    // strap sync runs through reset, else the mode flop only sees its reset level
    always_ff @(posedge i_clk) begin
        strap_s1_reg <= i_txd;
        strap_s2_reg <= strap_s1_reg;
    end

    // strap keeps following the pin while the external reset holds and one cycle after either reset, frozen after that
    always_comb begin
        serial_next = serial_reg;
        if (ext_s2_reg || !armed_reg) begin
            serial_next = strap_s2_reg; // R05
        end
    end

    assign core_rst = i_rst || ext_s2_reg; // R09
    assign o_rst = core_rst; // R10
    assign o_rst_n = !core_rst; // R10

    // parallel side: write taken on the rising edge of the write strobe
    logic wr_end, rd_end, sel_prev;
    always_ff @(posedge i_clk or posedge core_rst) begin
        if (core_rst) begin
            pin_prev_reg <= '1;
        end else begin
            pin_prev_reg <= pin_s2_reg;
        end
    end
    always_comb begin
        sel_prev = !pin_prev_reg.cs_n && !serial_reg; // R02
        wr_end = sel_prev && !pin_prev_reg.wr_n && pin_s2_reg.wr_n; // R02
        rd_end = sel_prev && !pin_prev_reg.rd_n && pin_s2_reg.rd_n; // R02
    end

    // serial receiver: 9 data bits, the ninth marks a command byte
    logic [15:0] div_reg, div_next;
    logic rx_on_reg, rx_on_next, rx_ev;
    logic [15:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0] rx_bit_reg, rx_bit_next;
    logic [8:0] rx_sh_reg, rx_sh_next;

    always_comb begin
        rx_on_next = rx_on_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bit_next = rx_bit_reg;
        rx_sh_next = rx_sh_reg;
        rx_ev = 1'b0;
        if (!rx_on_reg) begin
            if (serial_reg && !rx_s2_reg) begin // R07
                rx_on_next = 1'b1;
                rx_cnt_next = {1'b0, div_reg[15:1]};
                rx_bit_next = '0;
            end
        end else if (rx_cnt_reg != '0) begin
            rx_cnt_next = rx_cnt_reg - 16'h0001;
        end else begin
            rx_cnt_next = div_reg - 16'h0001;
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0) begin
                rx_on_next = !rx_s2_reg;
            end else if (rx_bit_reg == 4'ha) begin
                rx_on_next = 1'b0;
                rx_ev = rx_s2_reg;
            end else begin
                rx_sh_next = {rx_s2_reg, rx_sh_reg[8:1]};
            end
        end
    end

    always_ff @(posedge i_clk or posedge core_rst) begin
        if (core_rst) begin
            rx_on_reg <= 1'b0;
            rx_cnt_reg <= '0;
            rx_bit_reg <= '0;
            rx_sh_reg <= '0;
        end else begin
            rx_on_reg <= rx_on_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg <= rx_sh_next;
        end
    end

    // merged inbound byte event from whichever interface the strap chose
    logic ev_valid, ev_cmd;
    logic [7:0] ev_byte;
    always_comb begin
        ev_valid = serial_reg ? rx_ev : wr_end;
        ev_cmd = serial_reg ? rx_sh_reg[8] : pin_prev_reg.cmd_data_select; // R01
        ev_byte = serial_reg ? rx_sh_reg[7:0] : pin_prev_reg.data; // R03
    end

    // outbound bytes pass a two-entry buffer, drained by reads or by the sender
    logic push, fifo_ready, fifo_valid, pop, tx_take;
    logic [7:0] push_data, fifo_data;
    usbh_fifo #(.W(8), .D(2)) u_resp_fifo (
        .i_clk(i_clk),
        .i_rst(core_rst),
        .i_valid(push),
        .i_data(push_data),
        .o_ready(fifo_ready),
        .o_valid(fifo_valid),
        .o_data(fifo_data),
        .i_ready(pop)
    );
    assign pop = serial_reg ? tx_take : rd_end;
    assign o_host_data_bus = fifo_data; // R03
    assign o_host_data_bus_oe = !serial_reg && !pin_s2_reg.cs_n && !pin_s2_reg.rd_n; // R19

    // serial transmitter, 8N1
    logic tx_on_reg, tx_on_next;
    logic [15:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0] tx_bit_reg, tx_bit_next;
    logic [9:0] tx_sh_reg, tx_sh_next;

    always_comb begin
        tx_on_next = tx_on_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bit_next = tx_bit_reg;
        tx_sh_next = tx_sh_reg;
        tx_take = 1'b0;
        if (!tx_on_reg) begin
            if (serial_reg && fifo_valid) begin
                tx_take = 1'b1;
                tx_on_next = 1'b1;
                tx_sh_next = {1'b1, fifo_data, 1'b0};
                tx_cnt_next = div_reg - 16'h0001;
                tx_bit_next = '0;
            end
        end else if (tx_cnt_reg != '0) begin
            tx_cnt_next = tx_cnt_reg - 16'h0001;
        end else begin
            tx_cnt_next = div_reg - 16'h0001;
            tx_sh_next = {1'b1, tx_sh_reg[9:1]};
            tx_bit_next = tx_bit_reg + 4'h1;
            tx_on_next = (tx_bit_reg != 4'h9);
        end
    end

    always_ff @(posedge i_clk or posedge core_rst) begin
        if (core_rst) begin
            tx_on_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_bit_reg <= '0;
            tx_sh_reg <= '1;
        end else begin
            tx_on_reg <= tx_on_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_sh_reg <= tx_sh_next;
        end
    end
    assign o_txd = tx_sh_reg[0]; // R06
    // driven only once serial mode is frozen, so a board strapping low never fights us
    assign o_txd_oe = serial_reg && armed_reg && !core_rst; // R06

    // command engine and endpoint buffers
    usbh_state_t st_reg, st_next;
    logic [7:0] cmd_reg, cmd_next, arg0_reg, arg0_next, resp_reg, resp_next;
    logic [7:0] istat_reg, istat_next;
    logic argn_reg, argn_next, pend_reg, pend_next, host_reg, host_next;
    logic att_prev_reg;
    logic [5:0] idx_reg, idx_next;
    logic [6:0] in_cnt_reg, in_cnt_next, out_len_reg, out_len_next;
    logic [7:0] in_mem_reg [64];
    logic [7:0] out_mem_reg [64];
    logic out_we, in_we;
    usbh_xfer_t xfer_next;

    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        arg0_next = arg0_reg;
        resp_next = resp_reg;
        istat_next = istat_reg;
        argn_next = argn_reg;
        pend_next = pend_reg;
        host_next = host_reg;
        idx_next = idx_reg;
        in_cnt_next = in_cnt_reg;
        out_len_next = out_len_reg;
        div_next = div_reg;
        xfer_next = '0;
        push = 1'b0;
        push_data = resp_reg;
        out_we = 1'b0;
        in_we = i_usb_in.valid && (in_cnt_reg != `UH_BUF_BYTES); // R11
        if (in_we) begin
            in_cnt_next = in_cnt_reg + 7'h01;
        end
        if (ev_valid && ev_cmd) begin
            cmd_next = ev_byte; // R01
            argn_next = 1'b0;
            idx_next = '0;
            unique case (ev_byte)
                `UH_CMD_GET_VER: begin
                    resp_next = `UH_VER_FLAG | {2'b00, VERSION[5:0]};
                    st_next = USBH_ST_RESP;
                end
                `UH_CMD_CHECK, `UH_CMD_SET_BAUD, `UH_CMD_SET_MODE,
                `UH_CMD_WR_DATA, `UH_CMD_ISSUE: begin
                    st_next = USBH_ST_ARG;
                end
                `UH_CMD_TEST_CONN: begin
                    resp_next = i_dev_attached ? `UH_RET_SUCCESS : `UH_RET_ABORT; // R17
                    st_next = USBH_ST_RESP;
                end
                `UH_CMD_GET_STATUS: begin
                    resp_next = istat_reg; // R18
                    pend_next = 1'b0; // R18
                    st_next = USBH_ST_RESP;
                end
                `UH_CMD_RD_DATA: begin
                    st_next = USBH_ST_RDLEN;
                end
                default: begin
                    st_next = USBH_ST_IDLE;
                end
            endcase
        end else begin
            unique case (st_reg)
                USBH_ST_IDLE: begin
                end
                USBH_ST_ARG: begin
                    if (ev_valid) begin
                        st_next = USBH_ST_RESP;
                        resp_next = `UH_RET_SUCCESS; // R17
                        unique case (cmd_reg)
                            `UH_CMD_CHECK: begin
                                resp_next = ~ev_byte;
                            end
                            `UH_CMD_SET_BAUD: begin
                                arg0_next = ev_byte;
                                argn_next = 1'b1;
                                if (!argn_reg) begin
                                    st_next = USBH_ST_ARG;
                                end else if ({arg0_reg, ev_byte} < 16'h0010) begin
                                    resp_next = `UH_RET_ABORT; // R17
                                end else begin
                                    div_next = {arg0_reg, ev_byte}; // R16
                                end
                            end
                            `UH_CMD_SET_MODE: begin
                                host_next = (ev_byte == `UH_MODE_HOST); // R15
                            end
                            `UH_CMD_WR_DATA: begin
                                out_len_next = (ev_byte > 8'(`UH_BUF_BYTES)) ?
                                    `UH_BUF_BYTES : ev_byte[6:0]; // R11
                                st_next = (ev_byte == 8'h00) ? USBH_ST_IDLE : USBH_ST_WDATA;
                            end
                            default: begin
                                // issue a transfer over the attached peripheral
                                xfer_next.valid = host_reg; // R13
                                xfer_next.ttype = usbh_xfer_type_t'(ev_byte[`UH_ISSUE_TYPE_LSB +: 2]);
                                xfer_next.ep = ev_byte[3:0];
                                xfer_next.low_speed = i_low_speed; // R12
                                xfer_next.len = out_len_reg;
                                in_cnt_next = '0;
                                st_next = USBH_ST_IDLE;
                            end
                        endcase
                    end
                end
                USBH_ST_WDATA: begin
                    if (ev_valid) begin
                        out_we = 1'b1; // R11
                        idx_next = idx_reg + 6'h01;
                        if (7'(idx_reg) + 7'h01 == out_len_reg) begin
                            st_next = USBH_ST_IDLE;
                        end
                    end
                end
                USBH_ST_RESP: begin
                    push = 1'b1;
                    if (fifo_ready) begin
                        st_next = USBH_ST_IDLE;
                    end
                end
                USBH_ST_RDLEN: begin
                    push = 1'b1;
                    push_data = {1'b0, in_cnt_reg};
                    if (fifo_ready) begin
                        st_next = (in_cnt_reg == '0) ? USBH_ST_IDLE : USBH_ST_RDATA;
                    end
                end
                USBH_ST_RDATA: begin
                    // the buffer stalls this walk, so a slow reader loses no byte
                    push = 1'b1;
                    push_data = in_mem_reg[idx_reg];
                    if (fifo_ready) begin
                        idx_next = idx_reg + 6'h01;
                        if (7'(idx_reg) + 7'h01 == in_cnt_reg) begin
                            st_next = USBH_ST_IDLE;
                        end
                    end
                end
            endcase
        end
        // events come after the clear above so a same-cycle event stays pending
        if (host_reg && (i_dev_attached != att_prev_reg)) begin
            pend_next = 1'b1; // R14
            istat_next = i_dev_attached ? `UH_INT_CONNECT : `UH_INT_DISCONNECT; // R14
        end
        if (i_xfer_done) begin
            pend_next = 1'b1; // R04
            istat_next = i_xfer_ok ? `UH_INT_XFER_OK : `UH_INT_XFER_ERR;
        end
    end

    always_ff @(posedge i_clk or posedge core_rst) begin
        if (core_rst) begin
            st_reg <= USBH_ST_IDLE;
            cmd_reg <= '0;
            arg0_reg <= '0;
            resp_reg <= '0;
            istat_reg <= '0;
            argn_reg <= 1'b0;
            pend_reg <= 1'b0;
            host_reg <= 1'b1;
            att_prev_reg <= 1'b0;
            idx_reg <= '0;
            in_cnt_reg <= '0;
            out_len_reg <= '0;
            div_reg <= `UH_DIV_DEF; // R16
            o_xfer <= '0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            arg0_reg <= arg0_next;
            resp_reg <= resp_next;
            istat_reg <= istat_next;
            argn_reg <= argn_next;
            pend_reg <= pend_next;
            host_reg <= host_next;
            att_prev_reg <= i_dev_attached;
            idx_reg <= idx_next;
            in_cnt_reg <= in_cnt_next;
            out_len_reg <= out_len_next;
            div_reg <= div_next;
            o_xfer <= xfer_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (out_we) begin
            out_mem_reg[idx_reg] <= ev_byte;
        end
        if (in_we) begin
            in_mem_reg[in_cnt_reg[5:0]] <= i_usb_in.data;
        end
        o_out_data <= out_mem_reg[i_out_idx];
    end

    assign o_usb_in_ready = (in_cnt_reg != `UH_BUF_BYTES);
    assign o_int_n = !pend_reg; // R20
    assign o_host_mode = host_reg;
    assign o_link_connected_n = !(host_reg && i_dev_attached); // R08
endmodule : usbh_port
`default_nettype wire

// ---- bench/usbh_port_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module usbh_port_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ext_reset_in,
    input wire usbh_pkg::usbh_pins_t i_pins,
    input wire logic o_host_data_bus_oe,
    input wire logic o_int_n,
    input wire logic o_txd,
    input wire logic o_txd_oe,
    input wire logic o_rst,
    input wire logic o_rst_n,
    input wire logic o_link_connected_n,
    input wire logic o_host_mode,
    input wire logic i_dev_attached,
    input wire logic i_xfer_done
);
    import usbh_pkg::*;
    default clocking dc @(posedge i_clk);
    endclocking
    // the first edge samples flops before their reset lands
    logic live_reg = 1'b0;
    always_ff @(posedge i_clk) begin
        live_reg <= 1'b1;
    end
    default disable iff (!live_reg);
    property p_rpair; o_rst_n == !o_rst; endproperty
    a_rpair: assert property (p_rpair) else $error("rst pair");
    property p_ext; i_ext_reset_in [*3] |=> o_rst; endproperty
    a_ext: assert property (p_ext) else $error("ext rst");
    property p_irst; i_rst |-> o_int_n && o_rst; endproperty
    a_irst: assert property (p_irst) else $error("int in rst");
    property p_tx; i_rst |-> !o_txd_oe && o_txd; endproperty
    a_tx: assert property (p_tx) else $error("txd in rst");
    // sync flops make the bus enable lag the pins by two edges
    property p_oe; disable iff (i_rst) !o_rst && $past(!o_rst, 3) && !o_txd_oe
        |-> o_host_data_bus_oe == $past(!i_pins.cs_n && !i_pins.rd_n, 2); endproperty
    a_oe: assert property (p_oe) else $error("bus enable");
    property p_link; o_link_connected_n == !(o_host_mode && i_dev_attached); endproperty
    a_link: assert property (p_link) else $error("link");
    property p_att; disable iff (o_rst) $rose(i_dev_attached) && o_host_mode
        |-> ##[1:6] !o_int_n; endproperty
    a_att: assert property (p_att) else $error("attach irq");
    property p_done; disable iff (o_rst) i_xfer_done |-> ##[1:6] !o_int_n; endproperty
    a_done: assert property (p_done) else $error("done irq");
endmodule : usbh_port_chk
bind usbh_port usbh_port_chk i_chk (.i_clk, .i_rst, .i_ext_reset_in, .i_pins,
    .o_host_data_bus_oe, .o_int_n, .o_txd, .o_txd_oe, .o_rst, .o_rst_n,
    .o_link_connected_n, .o_host_mode, .i_dev_attached, .i_xfer_done);
`default_nettype wire

// ---- bench/usbh_host_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none
module usbh_host_bfm (
    input wire logic i_clk,
    input wire logic [7:0] i_bus,
    input wire logic i_bus_oe,
    input wire logic i_txd,
    input wire logic i_txd_oe,
    output usbh_pkg::usbh_pins_t o_pins,
    output logic o_txd_line,
    output logic o_rxd
);
    import usbh_pkg::*;
    usbh_pins_t p = '{1'b1, 1'b1, 1'b1, 1'b1, 8'hff};
    logic drv = 1'b0;
    logic [7:0] val = 8'h00;
    // a released bus reads as the pull-up level, never the last byte
    always_comb begin
        o_pins = p;
        o_pins.data = drv ? val : (i_bus_oe ? i_bus : 8'hff);
    end
    assign o_txd_line = i_txd_oe ? i_txd : 1'b0;
    assign o_rxd = 1'b1;
    task automatic strobe(input logic rd, input logic a0, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge i_clk);
        p.cs_n = 1'b0;
        p.cmd_data_select = a0;
        drv = !rd;
        val = d;
        p.rd_n = !rd;
        p.wr_n = rd;
        repeat (5) @(negedge i_clk);
        q = o_pins.data;
        p.rd_n = 1'b1;
        p.wr_n = 1'b1;
        repeat (4) @(negedge i_clk);
        p.cs_n = 1'b1;
        drv = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : strobe
endmodule : usbh_host_bfm
`default_nettype wire

// ---- bench/usbh_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "usbh_regs.svh"
module usbh_port_tb;
    import usbh_pkg::*;
    typedef struct packed {
        logic [7:0] cmd;
        logic argf;
        logic [7:0] arg;
        logic [7:0] exp;
    } usbh_row_t;
    localparam logic [7:0] VER = 8'h2a; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_rst = 1'b0;
    logic att = 1'b0;
    logic done = 1'b0;
    logic ok = 1'b0;
    logic [5:0] out_idx = 6'h00;
    usbh_byte_t usb_in = '0;
    usbh_pins_t pins;
    usbh_xfer_t xfer;
    usbh_xfer_t xcap = '0;
    logic [7:0] bus, out_data, q;
    logic oe, int_n, txd, txd_oe, txd_w, rxd, orst, orst_n, link_n, hmode, in_rdy;
    int mismatches = 0;
    int samples_checked = 0;
    usbh_row_t rows [5] = '{
        '{`UH_CMD_GET_VER, 1'b0, 8'h00, 8'haa},
        '{`UH_CMD_CHECK, 1'b1, 8'ha5, 8'h5a},
        '{`UH_CMD_CHECK, 1'b1, 8'h00, 8'hff},
        '{`UH_CMD_SET_MODE, 1'b1, 8'h06, 8'h51},
        '{`UH_CMD_TEST_CONN, 1'b0, 8'h00, 8'h5f}};
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (xfer.valid) begin
            xcap <= xfer;
        end
    end
    usbh_host_bfm i_host (.i_clk(clk), .i_bus(bus), .i_bus_oe(oe), .i_txd(txd),
        .i_txd_oe(txd_oe), .o_pins(pins), .o_txd_line(txd_w), .o_rxd(rxd));
    usbh_port #(.VERSION(VER)) i_dut (.i_clk(clk), .i_rst(rst), .i_ext_reset_in(ext_rst),
        .i_pins(pins), .o_host_data_bus(bus), .o_host_data_bus_oe(oe), .o_int_n(int_n),
        .i_txd(txd_w), .o_txd(txd), .o_txd_oe(txd_oe), .i_rxd(rxd), .o_rst(orst),
        .o_rst_n(orst_n), .o_link_connected_n(link_n), .o_host_mode(hmode),
        .i_dev_attached(att), .i_low_speed(1'b1), .o_xfer(xfer), .i_xfer_done(done),
        .i_xfer_ok(ok), .i_usb_in(usb_in), .o_usb_in_ready(in_rdy), .i_out_idx(out_idx),
        .o_out_data(out_data));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] c, input logic f, input logic [7:0] a);
        i_host.strobe(1'b0, 1'b1, c, q);
        if (f) begin
            i_host.strobe(1'b0, 1'b0, a, q);
        end
        repeat (2) @(negedge clk);
    endtask : cmd
    task automatic rd(input logic [7:0] e);
        i_host.strobe(1'b1, 1'b0, 8'h00, q);
        chk(16'(q), 16'(e));
    endtask : rd
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (15) @(negedge clk);
        chk({11'h0, orst, orst_n, int_n, oe, txd_oe}, 16'h0014);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            cmd(rows[i].cmd, rows[i].argf, rows[i].arg);
            rd(rows[i].exp);
        end
        att = 1'b1;
        repeat (6) @(negedge clk);
        chk({14'h0, link_n, int_n}, 16'h0000);
        cmd(`UH_CMD_GET_STATUS, 1'b0, 8'h00);
        rd(`UH_INT_CONNECT);
        chk(16'(int_n), 16'h0001);
        cmd(`UH_CMD_TEST_CONN, 1'b0, 8'h00);
        rd(`UH_RET_SUCCESS);
        for (int k = 0; k < 2; k++) begin
            ok = k[0];
            done = 1'b1;
            @(negedge clk);
            done = 1'b0;
            repeat (4) @(negedge clk);
            chk(16'(int_n), 16'h0000);
            cmd(`UH_CMD_GET_STATUS, 1'b0, 8'h00);
            rd(k ? `UH_INT_XFER_OK : `UH_INT_XFER_ERR);
        end
        cmd(`UH_CMD_WR_DATA, 1'b1, 8'h02);
        i_host.strobe(1'b0, 1'b0, 8'h3c, q);
        i_host.strobe(1'b0, 1'b0, 8'hc3, q);
        cmd(`UH_CMD_ISSUE, 1'b1, 8'h12);
        chk(16'(xcap), {1'b1, USBH_XFER_BULK, 4'h2, 1'b1, 7'h02});
        out_idx = 6'h01;
        repeat (2) @(negedge clk);
        chk(16'(out_data), 16'h00c3);
        usb_in = '{1'b1, 8'h5a};
        @(negedge clk);
        usb_in = '{1'b1, 8'ha5};
        @(negedge clk);
        usb_in = '0;
        chk(16'(in_rdy), 16'h0001);
        cmd(`UH_CMD_RD_DATA, 1'b0, 8'h00);
        rd(8'h02);
        rd(8'h5a);
        rd(8'ha5);
        ext_rst = 1'b1;
        repeat (4) @(negedge clk);
        chk({14'h0, orst, orst_n}, 16'h0002);
        ext_rst = 1'b0;
        repeat (6) @(negedge clk);
        print_verdict();
    end
endmodule : usbh_port_tb
`default_nettype wire
